// [logic/test_mux_b_pkg.sv]
// constants for the second test output selector
// assumes a 25 MHz system clock and a 32.768 kHz rtc wave from another domain
package test_mux_b_pkg;

	typedef logic [4:0] sel_t;

	// select codes
	localparam sel_t SEL_WATCHDOG   = 5'h00;
	localparam sel_t SEL_ONE_SECOND_PULSE   = 5'h01;
	localparam sel_t SEL_FOUR_SECOND_PULSE   = 5'h02;
	localparam sel_t SEL_RTC_WAVE   = 5'h03;
	localparam sel_t SEL_SPARE_1    = 5'h08;
	localparam sel_t SEL_SPARE_2    = 5'h09;
	localparam sel_t SEL_WAKE       = 5'h0a;
	localparam sel_t SEL_FRAME_SYNC = 5'h0b;
	localparam sel_t SEL_MASTER_CLK = 5'h0c;
	localparam sel_t SEL_GROUND     = 5'h0e;
	localparam sel_t SEL_IRQ_FIRST  = 5'h12;
	localparam sel_t SEL_IRQ_LAST   = 5'h18;
	localparam sel_t SEL_FLASH_CLK  = 5'h1f;

	// select value after a battery power-on clear
	localparam sel_t SEL_RESET = SEL_GROUND;

	localparam int IRQ_COUNT = 7;

	// synchroniser vector layout
	localparam int SRC_W          = 15;
	localparam int SRC_WATCHDOG   = 0;
	localparam int SRC_RTC_WAVE   = 1;
	localparam int SRC_SPARE_1    = 2;
	localparam int SRC_SPARE_2    = 3;
	localparam int SRC_WAKE       = 4;
	localparam int SRC_FRAME_SYNC = 5;
	localparam int SRC_MASTER_CLK = 6;
	localparam int SRC_IRQ_0      = 7;
	localparam int SRC_FLASH_CLK  = 14;

	// rtc timing, in rtc periods
	localparam int RTC_HZ         = 32768;
	localparam int PERIOD_1S      = RTC_HZ;
	localparam int PERIOD_4S      = 4 * RTC_HZ;
	localparam int DUTY_DIV       = 4;
	localparam logic [14:0] TOP_1S  = 15'(PERIOD_1S - 1);
	localparam logic [16:0] TOP_4S  = 17'(PERIOD_4S - 1);
	localparam logic [14:0] HIGH_1S = 15'(PERIOD_1S / DUTY_DIV);
	localparam logic [16:0] HIGH_4S = 17'(PERIOD_4S / DUTY_DIV);

endpackage

// [logic/rtc_pulse_if.sv]
// carries the synchronised rtc level to the pulse generator and the pulses back
// assumes both ends sit on the same system clock
`timescale 1ns/100ps
interface rtc_pulse_if;
	logic rtc_level;
	logic one_second_pulse;
	logic four_second_pulse;

	modport gen (
		input  rtc_level,
		output one_second_pulse,
		output four_second_pulse
	);
	modport use_side (
		output rtc_level,
		input  one_second_pulse,
		input  four_second_pulse
	);
endinterface

// [logic/rtc_pulse_gen.sv]
// one and four second calibration pulses counted from rtc rising edges
// assumes rtc_level is already synchronised to clock_i
`timescale 1ns/100ps
module rtc_pulse_gen
	import test_mux_b_pkg::*;
(
	input  wire logic  clock_i,
	input  wire logic  rst_i,
	rtc_pulse_if.gen   pif
);
	logic        rtc_prev_ff;
	logic [14:0] cnt_1s_ff;
	logic [16:0] cnt_4s_ff;
	logic        one_second_pulse_ff;
	logic        four_second_pulse_ff;
	logic        rtc_rise;

	assign rtc_rise = pif.rtc_level & ~rtc_prev_ff;

	always_ff @(posedge clock_i) begin
		if (rst_i)
			rtc_prev_ff <= 1'b0;
		else
			rtc_prev_ff <= pif.rtc_level;
	end

	// counting rtc edges keeps the pulses true to the crystal, not to clock_i
	// counters restart at their top so the first rtc rise opens a full-length high quarter
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cnt_1s_ff   <= TOP_1S;
			one_second_pulse_ff <= 1'b0;
		end else if (rtc_rise) begin
			cnt_1s_ff   <= (cnt_1s_ff == TOP_1S) ? '0 : cnt_1s_ff + 15'h0001;
			one_second_pulse_ff <= (cnt_1s_ff == TOP_1S) || (cnt_1s_ff < HIGH_1S - 15'h0001); // R2
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cnt_4s_ff   <= TOP_4S;
			four_second_pulse_ff <= 1'b0;
		end else if (rtc_rise) begin
			cnt_4s_ff   <= (cnt_4s_ff == TOP_4S) ? '0 : cnt_4s_ff + 17'h00001;
			four_second_pulse_ff <= (cnt_4s_ff == TOP_4S) || (cnt_4s_ff < HIGH_4S - 17'h00001); // R3
		end
	end

	assign pif.one_second_pulse  = one_second_pulse_ff;
	assign pif.four_second_pulse = four_second_pulse_ff;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_one_sec_duty: assert property (one_second_pulse_ff == (cnt_1s_ff < HIGH_1S)) // R2
		else $error("one second pulse level disagrees with quarter period");
	a_four_sec_duty: assert property (four_second_pulse_ff == (cnt_4s_ff < HIGH_4S)) // R3
		else $error("four second pulse level disagrees with quarter period");
	a_one_sec_wrap: assert property (rtc_rise && cnt_1s_ff == TOP_1S |=> cnt_1s_ff == '0) // R2
		else $error("one second counter did not wrap");
endmodule

// [logic/test_mux_b.sv]
// selector driving one internal digital signal onto the second test output pin
// assumes all source inputs are asynchronous to clock_i; select writes come on clock_i
`timescale 1ns/100ps

// Overview of operation
// R1: code 0 sends the watchdog expiry signal to the test output.
// R2: code 1 sends a one second pulse, high a quarter of the period.
// R3: code 2 sends a four second pulse, high a quarter of the period.
// R4: code 3 sends the 32.768 kHz rtc waveform.
// R5: codes 8 and 9 copy spare bit 1 and spare bit 2.
// R6: code a sends the wake indication.
// R7: code b sends the converter frame sync marker.
// R8: code e holds the output static low at digital ground.
// R9: software uses only listed codes; other codes are reserved.
// R10: the observer averages several pulse periods to filter jitter.
// R11: the select value survives ordinary resets, cleared only at battery power-on.
// R12: software clears the segment map bit so the pin acts as test output.
// R13: codes 12 to 18 send irq lines 0 to 6; c master clock; 1f flash clock.
module test_mux_b
	import test_mux_b_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       battery_por_i,
	input  wire logic       test_select_we_i,
	input  wire logic [4:0] test_select_b_i,
	input  wire logic       segment_map_bit_i,
	input  wire logic       watchdog_expired_i,
	input  wire logic       rtc_clock_wave_i,
	input  wire logic       spare_bit_1_i,
	input  wire logic       spare_bit_2_i,
	input  wire logic       wake_i,
	input  wire logic       frame_sync_marker_i,
	input  wire logic       master_clock_out_i,
	input  wire logic [6:0] irq_line_i,
	input  wire logic       flash_monitor_clock_i,
	output logic [4:0]      test_select_b_o,
	output logic            test_out_b_o,
	output logic            test_out_b_oe_o
);
	sel_t             sel_ff;
	logic [SRC_W-1:0] meta_ff;
	logic [SRC_W-1:0] sync_ff;
	logic [SRC_W-1:0] src_raw;
	logic             out_ff;
	logic             oe_ff;
	logic             nxt_out;
	logic [2:0]       irq_idx;

	rtc_pulse_if pif ();

	rtc_pulse_gen u_pulse (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pif     (pif.gen)
	);

	assign src_raw = {flash_monitor_clock_i, irq_line_i, master_clock_out_i,
		frame_sync_marker_i, wake_i, spare_bit_2_i, spare_bit_1_i,
		rtc_clock_wave_i, watchdog_expired_i};

	// fast clocks such as the master clock alias at 25 MHz sampling; usable only as activity
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= src_raw;
			sync_ff <= meta_ff;
		end
	end

	assign pif.rtc_level = sync_ff[SRC_RTC_WAVE];

	// battery-backed: ordinary reset leaves it alone
	always_ff @(posedge clock_i) begin
		if (battery_por_i)
			sel_ff <= SEL_RESET;
		else if (test_select_we_i)
			sel_ff <= test_select_b_i; // R11
	end

	assign test_select_b_o = sel_ff;
	assign irq_idx = 3'(sel_ff - SEL_IRQ_FIRST);

	// reserved codes give a quiet low rather than an arbitrary source
	always_comb begin
		nxt_out = 1'b0;
		case (sel_ff)
			SEL_WATCHDOG:   nxt_out = sync_ff[SRC_WATCHDOG];   // R1
			SEL_ONE_SECOND_PULSE:   nxt_out = pif.one_second_pulse;    // R2
			SEL_FOUR_SECOND_PULSE:   nxt_out = pif.four_second_pulse;   // R3
			SEL_RTC_WAVE:   nxt_out = sync_ff[SRC_RTC_WAVE];   // R4
			SEL_SPARE_1:    nxt_out = sync_ff[SRC_SPARE_1];    // R5
			SEL_SPARE_2:    nxt_out = sync_ff[SRC_SPARE_2];    // R5
			SEL_WAKE:       nxt_out = sync_ff[SRC_WAKE];       // R6
			SEL_FRAME_SYNC: nxt_out = sync_ff[SRC_FRAME_SYNC]; // R7
			SEL_MASTER_CLK: nxt_out = sync_ff[SRC_MASTER_CLK]; // R13
			SEL_GROUND:     nxt_out = 1'b0;                    // R8
			SEL_FLASH_CLK:  nxt_out = sync_ff[SRC_FLASH_CLK];  // R13
			default: begin
				if (sel_ff >= SEL_IRQ_FIRST && sel_ff <= SEL_IRQ_LAST)
					nxt_out = sync_ff[SRC_IRQ_0 + int'(irq_idx)]; // R13
				else
					nxt_out = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i)
			out_ff <= 1'b0;
		else
			out_ff <= nxt_out;
	end

	// the segment driver owns the pin while its map bit is set
	always_ff @(posedge clock_i) begin
		if (rst_i)
			oe_ff <= 1'b0;
		else
			oe_ff <= ~segment_map_bit_i;
	end

	assign test_out_b_o    = out_ff;
	assign test_out_b_oe_o = oe_ff;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i || battery_por_i);

	sequence s_src_rises(int idx);
		!sync_ff[idx] ##1 sync_ff[idx];
	endsequence

	a_watchdog_route: assert property ( // R1
		sel_ff == SEL_WATCHDOG && !test_select_we_i ##0 s_src_rises(SRC_WATCHDOG)
		|=> test_out_b_o && $past(sel_ff) == SEL_WATCHDOG)
		else $error("watchdog expiry not routed");
	a_one_second_pulse_route: assert property ( // R2
		sel_ff == SEL_ONE_SECOND_PULSE |=> test_out_b_o == $past(pif.one_second_pulse))
		else $error("one second pulse not routed");
	a_four_second_pulse_route: assert property ( // R3
		sel_ff == SEL_FOUR_SECOND_PULSE |=> test_out_b_o == $past(pif.four_second_pulse))
		else $error("four second pulse not routed");
	a_rtc_wave_delay: assert property ( // R4
		sel_ff == SEL_RTC_WAVE && !test_select_we_i [*3]
		|-> test_out_b_o == $past(rtc_clock_wave_i, 3))
		else $error("rtc wave not routed with three cycle latency");
	a_spare_route: assert property ( // R5
		(sel_ff == SEL_SPARE_1 || sel_ff == SEL_SPARE_2)
		|=> test_out_b_o == ($past(sel_ff) == SEL_SPARE_1 ?
			$past(sync_ff[SRC_SPARE_1]) : $past(sync_ff[SRC_SPARE_2])))
		else $error("spare bit not routed");
	a_wake_route: assert property ( // R6
		sel_ff == SEL_WAKE |=> test_out_b_o == $past(sync_ff[SRC_WAKE]))
		else $error("wake indication not routed");
	a_frame_sync: assert property ( // R7
		sel_ff == SEL_FRAME_SYNC |=> test_out_b_o == $past(sync_ff[SRC_FRAME_SYNC]))
		else $error("frame sync not routed");
	a_ground_static: assert property ( // R8
		sel_ff == SEL_GROUND [*2] |-> !test_out_b_o)
		else $error("ground selection not static low");
	a_select_kept: assert property ( // R11
		@(posedge clock_i) disable iff (battery_por_i)
		rst_i && !test_select_we_i |=> sel_ff == $past(sel_ff))
		else $error("select value lost across reset");
	a_irq_route: assert property ( // R13
		sel_ff >= SEL_IRQ_FIRST && sel_ff <= SEL_IRQ_LAST
		|=> test_out_b_o == $past(sync_ff[SRC_IRQ_0 + int'(irq_idx)]))
		else $error("irq line not routed");
endmodule

// [tb/pin_observer.sv]
// tester model that watches the second test pin while the block drives it
// assumes the pin is sampled on the system clock; clear_i restarts the averaging
`timescale 1ns/100ps
module pin_observer (
	input  wire logic        clock_i,
	input  wire logic        clear_i,
	input  wire logic        pin_i,
	input  wire logic        oe_i,
	output logic [31:0]      high_len_o,
	output logic [31:0]      period_sum_o,
	output logic [7:0]       period_cnt_o
);
	logic        seen;
	logic        last_ff;
	logic        seen_ff;
	logic [31:0] run_ff;
	logic [31:0] gap_ff;

	assign seen = pin_i & oe_i;

	always_ff @(posedge clock_i) begin
		last_ff <= seen;
		run_ff <= seen ? run_ff + 32'h1 : 32'h0;
		if (last_ff & ~seen) begin
			high_len_o <= run_ff;
		end
	end

	// one period jitters, so periods are summed and averaged by the reader
	always_ff @(posedge clock_i) begin
		gap_ff <= gap_ff + 32'h1;
		if (clear_i) begin
			seen_ff <= 1'b0;
			period_sum_o <= 32'h0;
			period_cnt_o <= 8'h0;
		end else if (seen & ~last_ff) begin
			gap_ff <= 32'h1;
			seen_ff <= 1'b1;
			if (seen_ff) begin
				period_sum_o <= period_sum_o + gap_ff;
				period_cnt_o <= period_cnt_o + 8'h1;
			end
		end
	end
endmodule

// [tb/testbench.sv]
// self-checking bench for the second test output selector
// assumes a 25 MHz clock and an rtc wave made here, 6 clocks a period
`timescale 1ns/100ps
module testbench;
	import test_mux_b_pkg::*;
	localparam int RTC_DIV = 6;
	localparam logic [4:0] CODES [15] = '{5'h00, 5'h03, 5'h08, 5'h09, 5'h0a, 5'h0b,
		5'h0c, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h1f};
	logic clock_i = 1'b0, rst_i, por, we, seg, rtc_run, clear;
	logic [4:0] sel_in, sel_o;
	logic [14:0] srcv;
	logic [2:0] rtc_cnt;
	logic out, oe;
	logic [31:0] high_len, psum;
	logic [7:0] pcnt;
	int bad_count = 0, samples_checked = 0;

	always #20 clock_i = ~clock_i;
	always_ff @(posedge clock_i) rtc_cnt <= (!rtc_run || rtc_cnt == 3'h5) ? 3'h0 : rtc_cnt + 3'h1;

	test_mux_b DUT (.clock_i(clock_i), .rst_i(rst_i), .battery_por_i(por),
		.test_select_we_i(we), .test_select_b_i(sel_in), .segment_map_bit_i(seg),
		.watchdog_expired_i(srcv[SRC_WATCHDOG]),
		.rtc_clock_wave_i(rtc_run ? (rtc_cnt >= 3'h3) : srcv[SRC_RTC_WAVE]),
		.spare_bit_1_i(srcv[SRC_SPARE_1]), .spare_bit_2_i(srcv[SRC_SPARE_2]),
		.wake_i(srcv[SRC_WAKE]), .frame_sync_marker_i(srcv[SRC_FRAME_SYNC]),
		.master_clock_out_i(srcv[SRC_MASTER_CLK]), .irq_line_i(srcv[SRC_IRQ_0 +: 7]),
		.flash_monitor_clock_i(srcv[SRC_FLASH_CLK]), .test_select_b_o(sel_o),
		.test_out_b_o(out), .test_out_b_oe_o(oe));
	pin_observer obs (.clock_i(clock_i), .clear_i(clear), .pin_i(out), .oe_i(oe),
		.high_len_o(high_len), .period_sum_o(psum), .period_cnt_o(pcnt));

	task automatic check(input logic [31:0] seen, input logic [31:0] expect_v);
		samples_checked++;
		if (seen !== expect_v) begin
			bad_count++;
			$display("[ERR] %0t: saw %h, expected %h", $time, seen, expect_v);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wr_sel(input logic [4:0] code);
		@(posedge clock_i);
		we <= 1'b1;
		sel_in <= code;
		@(posedge clock_i);
		we <= 1'b0;
		#1;
		check(sel_o, code);
	endtask
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// select survives an ordinary reset; only the battery clear sets ground
	task automatic t_retention;
		wr_sel(5'h0b);
		@(posedge clock_i) rst_i <= 1'b1;
		tick(2);
		check(out, 1'b0);
		@(posedge clock_i) rst_i <= 1'b0;
		tick(2);
		check(sel_o, 5'h0b);
		@(posedge clock_i) por <= 1'b1;
		@(posedge clock_i) por <= 1'b0;
		tick(1);
		check(sel_o, 5'h0e);
	endtask
	// each code routed from a source input (all but 1, 2 and e), with the three-edge path latency
	task automatic t_route;
		for (int i = 0; i < 15; i++) begin
			wr_sel(CODES[i]);
			tick(3);
			@(posedge clock_i) srcv[i] <= 1'b1;
			tick(2);
			check(out, 1'b0);
			tick(1);
			check(out, 1'b1);
			@(posedge clock_i) srcv <= '0;
			tick(3);
			check(out, 1'b0);
		end
	endtask
	// ground and a reserved code stay low with every source high
	task automatic t_static;
		@(posedge clock_i) srcv <= '1;
		wr_sel(5'h0e);
		tick(4);
		check(out, 1'b0);
		wr_sel(5'h04);
		tick(4);
		check(out, 1'b0);
		@(posedge clock_i) srcv <= '0;
	endtask
	task automatic t_pin_enable;
		@(posedge clock_i) seg <= 1'b1;
		tick(1);
		check(oe, 1'b0);
		@(posedge clock_i) seg <= 1'b0;
		tick(1);
		check(oe, 1'b1);
	endtask
	task automatic t_rtc_wave;
		@(posedge clock_i) rtc_run <= 1'b1;
		wr_sel(5'h03);
		@(posedge clock_i) clear <= 1'b1;
		@(posedge clock_i) clear <= 1'b0;
		tick(60);
		check(32'(pcnt >= 8'h8), 32'h1);
		check(psum / pcnt, RTC_DIV);
	endtask
	// quarter duty of one second pulse, four second pulse still high after it
	task automatic t_pulses;
		@(posedge clock_i) rtc_run <= 1'b0;
		wr_sel(5'h01);
		@(posedge clock_i) rst_i <= 1'b1;
		@(posedge clock_i) rst_i <= 1'b0;
		@(posedge clock_i) rtc_run <= 1'b1;
		tick(52000);
		check(high_len, RTC_HZ / DUTY_DIV * RTC_DIV);
		check(out, 1'b0);
		wr_sel(5'h02);
		tick(4);
		check(out, 1'b1);
	endtask

	initial begin
		rst_i <= 1'b1;
		por <= 1'b1;
		{we, seg, rtc_run, clear} <= '0;
		sel_in <= 5'h00;
		srcv <= '0;
		tick(19);
		@(posedge clock_i) {rst_i, por} <= 2'b00;
		tick(1);
		check(sel_o, 5'h0e);
		t_retention();
		t_route();
		t_static();
		t_pin_enable();
		t_rtc_wave();
		t_pulses();
		end_sim();
	end
	initial begin
		#(40 * 70000);
		bad_count++;
		end_sim();
	end
endmodule
